// File: qbg_map.svh
`ifndef QBG_MAP_SVH
`define QBG_MAP_SVH
// special-function addresses of the port registers
`define QBG_ADDR_LATCH 8'hB0
`define QBG_ADDR_MODE_HI 8'hB1
`define QBG_ADDR_MODE_LO 8'hB2
// reset values
`define QBG_LATCH_RST 8'hFF
`define QBG_MODE_RST 8'h00
// number of pins and strong pull-up pulse length in cpu clocks
`define QBG_PIN_COUNT 6
`define QBG_STRONG_CYCLES 2'h2
`endif

// File: qbg_pkg.sv
package qbg_pkg;
  typedef enum logic [3:0] {
    QBG_MODE_QUASI = 4'h1,
    QBG_MODE_PUSH = 4'h2,
    QBG_MODE_INPUT = 4'h4,
    QBG_MODE_OPEN = 4'h8
  } qbg_mode_t;

  // special-function bus access from the cpu core
  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic rmw;
    logic [7:0] wdata;
  } qbg_sfr_req_t;

  // per-pin pad controls
  typedef struct packed {
    logic [5:0] strong_up;
    logic [5:0] weak_up;
    logic [5:0] vweak_up;
    logic [5:0] pull_down;
  } qbg_pad_ctl_t;
endpackage

// File: qbg_pin_cell.sv
`timescale 1ns/1ps
`include "qbg_map.svh"
// one pin: mode decode, pull-up/pull-down enables, strong pulse timer
module qbg_pin_cell
  import qbg_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic latch_bit,
  input wire logic latch_rise,
  input wire logic mode_hi,
  input wire logic mode_lo,
  input wire logic pin_level,
  output logic strong_up,
  output logic weak_up,
  output logic vweak_up,
  output logic pull_down
);
  logic [1:0] pulse_cnt_q;
  logic [1:0] pulse_cnt_d;
  qbg_mode_t mode;

  function automatic qbg_mode_t decode_mode(input logic hi, input logic lo);
    case ({hi, lo})
      2'h0: decode_mode = QBG_MODE_QUASI;
      2'h1: decode_mode = QBG_MODE_PUSH;
      2'h2: decode_mode = QBG_MODE_INPUT;
      default: decode_mode = QBG_MODE_OPEN;
    endcase
  endfunction

  assign mode = decode_mode(mode_hi, mode_lo);
  wire is_quasi = (mode == QBG_MODE_QUASI);
  wire is_push = (mode == QBG_MODE_PUSH);
  wire is_open = (mode == QBG_MODE_OPEN);
  // restart the pulse on each 0->1 latch change in quasi mode
  assign pulse_cnt_d = (latch_rise && is_quasi) ? `QBG_STRONG_CYCLES :
                       (pulse_cnt_q != 2'h0) ? pulse_cnt_q - 2'h1 : 2'h0;
  wire strong_d = (is_quasi && pulse_cnt_d != 2'h0 && latch_bit) ||
                  (is_push && latch_bit);
  wire weak_d = is_quasi && latch_bit && pin_level;
  wire vweak_d = is_quasi && latch_bit;
  // input mode gets none of the drivers
  wire down_d = (is_quasi || is_push || is_open) && !latch_bit;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pulse_cnt_q <= 2'h0;
      strong_up <= 1'b0;
      weak_up <= 1'b0;
      vweak_up <= 1'b0;
      pull_down <= 1'b0;
    end else begin
      pulse_cnt_q <= pulse_cnt_d;
      strong_up <= strong_d;
      weak_up <= weak_d;
      vweak_up <= vweak_d;
      pull_down <= down_d;
    end
  end
endmodule // qbg_pin_cell

// File: qbg_gpio_port.sv
`timescale 1ns/1ps
`include "qbg_map.svh"
module qbg_gpio_port
  import qbg_pkg::*;
#(
  parameter int PINS = `QBG_PIN_COUNT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire qbg_pkg::qbg_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  output logic sfr_rvalid,
  input wire logic [PINS-1:0] pin_schmitt_in,
  output qbg_pkg::qbg_pad_ctl_t pad_ctl
);
  import qbg_pkg::*;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [PINS-1:0] latch_q;
  logic [PINS-1:0] latch_d;
  logic [PINS-1:0] mode_hi_q;
  logic [PINS-1:0] mode_hi_d;
  logic [PINS-1:0] mode_lo_q;
  logic [PINS-1:0] mode_lo_d;
  logic [PINS-1:0] pin_meta_q;
  logic [PINS-1:0] pin_sync_q;
  logic [7:0] rdata_d;

  wire sel_latch = (sfr_req.addr == `QBG_ADDR_LATCH);
  wire sel_hi = (sfr_req.addr == `QBG_ADDR_MODE_HI);
  wire sel_lo = (sfr_req.addr == `QBG_ADDR_MODE_LO);
  // bit set/clear arrives as a read-modify-write of the whole byte
  assign latch_d = (sfr_req.wr && sel_latch) ? sfr_req.wdata[PINS-1:0] : latch_q;
  assign mode_hi_d = (sfr_req.wr && sel_hi) ? sfr_req.wdata[PINS-1:0] : mode_hi_q;
  assign mode_lo_d = (sfr_req.wr && sel_lo) ? sfr_req.wdata[PINS-1:0] : mode_lo_q;

  // plain reads of the latch see the pins, rmw reads see the latch;
  // the pin path is the same in every mode
  wire [PINS-1:0] latch_view = sfr_req.rmw ? latch_q : pin_sync_q;
  assign rdata_d = !sfr_req.rd ? 8'h00 :
                   sel_latch ? {2'h0, latch_view} :
                   sel_hi ? {2'h0, mode_hi_q} :
                   sel_lo ? {2'h0, mode_lo_q} : 8'h00;

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      latch_q <= PINS'(`QBG_LATCH_RST);
      mode_hi_q <= PINS'(`QBG_MODE_RST);
      mode_lo_q <= PINS'(`QBG_MODE_RST);
      sfr_rdata <= 8'h00;
      sfr_rvalid <= 1'b0;
    end else begin
      latch_q <= latch_d;
      mode_hi_q <= mode_hi_d;
      mode_lo_q <= mode_lo_d;
      sfr_rdata <= rdata_d;
      sfr_rvalid <= sfr_req.rd;
    end
  end

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  // two stages: the pad level is asynchronous to the core in practice
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      pin_meta_q <= '0;
      pin_sync_q <= '0;
    end else begin
      pin_meta_q <= pin_schmitt_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // per-pin drivers
  // ----------------------------------------------------------------
  wire [PINS-1:0] latch_rise = latch_d & ~latch_q;
  logic [PINS-1:0] strong_w;
  logic [PINS-1:0] weak_w;
  logic [PINS-1:0] vweak_w;
  logic [PINS-1:0] down_w;

  for (genvar i = 0; i < PINS; i++) begin : g_pin
    qbg_pin_cell u_cell (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .latch_bit(latch_d[i]),
      .latch_rise(latch_rise[i]),
      .mode_hi(mode_hi_d[i]),
      .mode_lo(mode_lo_d[i]),
      .pin_level(pin_sync_q[i]),
      .strong_up(strong_w[i]),
      .weak_up(weak_w[i]),
      .vweak_up(vweak_w[i]),
      .pull_down(down_w[i])
    );
  end

  // cell outputs are flip-flops already
  assign pad_ctl.strong_up = strong_w;
  assign pad_ctl.weak_up = weak_w;
  assign pad_ctl.vweak_up = vweak_w;
  assign pad_ctl.pull_down = down_w;
endmodule // qbg_gpio_port

// File: qbg_gpio_port_checker.sv
`timescale 1ns/1ps
module qbg_gpio_port_checker #(parameter int PINS = 6) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire qbg_pkg::qbg_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  input wire logic sfr_rvalid,
  input wire logic [PINS-1:0] pin_schmitt_in,
  input wire qbg_pkg::qbg_pad_ctl_t pad_ctl
);
  import qbg_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic rd = sfr_req.rd;
  wire logic hit = sfr_req.addr inside {[8'hB0:8'hB2]};
  wire logic [5:0] s = pad_ctl.strong_up, w = pad_ctl.weak_up, v = pad_ctl.vweak_up;
  wire logic [5:0] d = pad_ctl.pull_down;
  a_rd_answer: assert property (rd |=> sfr_rvalid) else $error("no answer");
  a_unmap_zero: assert property (rd && !hit |=> sfr_rdata == 8'h00) else $error("unmap");
  a_mode_top: assert property (rd && hit && sfr_req.addr != 8'hB0 |=> sfr_rdata[7:6] == 2'b00)
    else $error("mode top");
  a_no_fight: assert property ((d & (s | w | v)) == 6'h00) else $error("fight");
  a_weak_vweak: assert property ((w & ~v) == 6'h00) else $error("weak");
  // sync latency of three edges, allowed to sit one edge later
  a_weak_pin: assert property ((w & ~$past(pin_schmitt_in, 3) & ~$past(pin_schmitt_in, 4)) == 6'h00)
    else $error("weak pin");
  a_strong_two: assert property ((s[0] && v[0]) [*2] |=> !s[0]) else $error("long");
  a_strong_hold: assert property ($rose(s[0]) && v[0] |=> s[0] || d[0]) else $error("short");
  c_read: cover property (sfr_rvalid);
  c_pulse: cover property (s[0] && v[0]);
  c_push: cover property (s[0] && !v[0]);
endmodule // qbg_gpio_port_checker
bind qbg_gpio_port qbg_gpio_port_checker #(.PINS(PINS)) chk_u (.core_clk(core_clk),
  .rst_n(rst_n), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .sfr_rvalid(sfr_rvalid),
  .pin_schmitt_in(pin_schmitt_in), .pad_ctl(pad_ctl));

// File: qbg_pad_model.sv
`timescale 1ns/1ps
module qbg_pad_model (
  input wire logic [5:0] ext_low,
  input wire qbg_pkg::qbg_pad_ctl_t pad_ctl,
  output logic [5:0] pin
);
  import qbg_pkg::*;
  // board pull-up on every pin, so a released pin reads high
  assign pin = ~pad_ctl.pull_down & ~ext_low;
endmodule // qbg_pad_model

// File: quasi_bidir_gpio_port_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s %h %h", n, e, g); end end
module quasi_bidir_gpio_port_tb_top;
  import qbg_pkg::*;
  logic core_clk, rst_n, rv;
  logic [5:0] lo, pin;
  logic [7:0] rdat;
  qbg_sfr_req_t req;
  qbg_pad_ctl_t pad;
  int errors = 0, comparisons = 0;
  qbg_gpio_port dut_u (.core_clk(core_clk), .rst_n(rst_n), .sfr_req(req), .sfr_rdata(rdat),
    .sfr_rvalid(rv), .pin_schmitt_in(pin), .pad_ctl(pad));
  qbg_pad_model brd_u (.ext_low(lo), .pad_ctl(pad), .pin(pin));
  function automatic qbg_pad_ctl_t ep(logic [5:0] h, l, q, p);
    return '{~h & l & q, ~h & ~l & q & p, ~h & ~l & q, ~(h & ~l) & ~q};
  endfunction
  task automatic bus(logic [7:0] a, logic [2:0] op, logic [7:0] dat);
    @(posedge core_clk) req <= '{a, op[2], op[1], op[0], dat};
    @(posedge core_clk) req <= '0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic m, logic [7:0] e);
    bus(a, {2'b01, m}, 8'h00);
    `CHK("rdata", {1'b1, e}, {rv, rdat})
  endtask
  task automatic pk(logic [5:0] h, l, q, p);
    repeat (4) @(posedge core_clk);
    #1;
    `CHK("pad_ctl", ep(h, l, q, p), pad)
  endtask
  task automatic md(logic [5:0] h, l);
    bus(8'hB1, 3'b100, {2'b11, h});
    bus(8'hB2, 3'b100, {2'b11, l});
    pk(h, l, 6'h2A, 6'h3F);
  endtask
  task automatic t_reset;
    rd(8'hB1, 1'b0, 8'h00);
    rd(8'hB2, 1'b0, 8'h00);
    pk(6'h00, 6'h00, 6'h3F, 6'h3F);
    bus(8'hB3, 3'b100, 8'hFF);
    rd(8'hB3, 1'b0, 8'h00);
    rd(8'hB0, 1'b1, 8'h3F);
  endtask
  task automatic t_quasi;
    bus(8'hB0, 3'b100, 8'h00);
    pk(6'h00, 6'h00, 6'h00, 6'h3F);
    bus(8'hB0, 3'b100, 8'hC1);
    `CHK("strong_up", 6'h01, pad.strong_up)
    @(posedge core_clk);
    #1;
    `CHK("strong_up", 6'h01, pad.strong_up)
    @(posedge core_clk);
    #1;
    `CHK("strong_up", 6'h00, pad.strong_up)
    pk(6'h00, 6'h00, 6'h01, 6'h3F);
    rd(8'hB0, 1'b1, 8'h01);
  endtask
  task automatic t_modes;
    bus(8'hB0, 3'b100, 8'h2A);
    md(6'h00, 6'h3F);
    md(6'h3F, 6'h00);
    md(6'h3F, 6'h3F);
    rd(8'hB0, 1'b0, 8'h2A);
    md(6'h0C, 6'h0A);
    rd(8'hB1, 1'b0, 8'h0C);
    md(6'h00, 6'h00);
  endtask
  task automatic t_pin;
    bus(8'hB0, 3'b100, 8'h3F);
    @(posedge core_clk) lo <= 6'h10;
    pk(6'h00, 6'h00, 6'h3F, 6'h2F);
    rd(8'hB0, 1'b0, 8'h2F);
    rd(8'hB0, 1'b1, 8'h3F);
  endtask
  task automatic results;
    if (errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial begin
    rst_n = 1'b0;
    lo = 6'h00;
    req = '0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    t_reset();
    t_quasi();
    t_modes();
    t_pin();
    results();
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    errors++;
    results();
  end
endmodule // quasi_bidir_gpio_port_tb_top
